/* File: src/retimer_channel_control_status_regs.sv */
// Register bank for one retimer channel plus shared load controls.
// Assumes a plain register port on i_sys_clk, status pins from other
// clock domains, and a load engine and observe sources on this clock.
//
// Summary of operation
// - Six-bit read-only count of load attempts.
// - Two-bit load status: done, failed, busy.
// - Speed bit picks 400 or 100 kHz load.
// - Core reset bit resets channel state machines.
// - Register reset bit restores channel register defaults.
// - Recovered-clock domain reset bit drives domain reset.
// - Reference reset acts only with reference clock.
// - Raw signal detect readable, not latched.
// - Polarity inversion flag readable from checker.
// - Lock-loss flag after lock, cleared on read.
// - Lock-loss flag works only when enabled.
// - Four-bit detected pattern code readable.
// - Signal-loss flag after acquire, clear on read.
// - Status byte chosen by four-bit select field.
`include "retimer_regs_cfg.svh"

module retimer_channel_control_status_regs (
  input wire logic i_sys_clk,                     // 40 MHz clock
  input wire logic i_rst_n,                       // Async reset, low
  input wire logic i_clk_en,                      // Freezes state when low
  input wire retimer_regs_pkg::addr_t i_addr,     // Register address
  input wire retimer_regs_pkg::byte_t i_wr_data,  // Write data
  input wire logic i_wr,                          // Write strobe
  input wire logic i_rd,                          // Read strobe
  output retimer_regs_pkg::byte_t o_rd_data,      // Read data, next cycle
  input wire logic i_sig_detect_pin,              // Signal detector
  input wire logic i_lock_pin,                    // Clock recovery lock
  input wire logic i_pol_inv_pin,                 // Polarity inverted
  input wire retimer_regs_pkg::pat_code_t i_pattern_pin, // Pattern code
  input wire logic i_ref_clk_present_pin,         // Reference clock seen
  input wire retimer_regs_pkg::obs_bus_t i_observe_src, // Observe bytes
  input wire logic i_load_attempt,                // Load attempt started
  input wire logic i_load_ok,                     // Attempt succeeded
  input wire logic i_load_err,                    // Attempt failed
  output logic o_load_fast,                       // Fast load mode
  output logic o_load_tick,                       // Load bit-rate tick
  output logic o_core_rst,                        // Core domain reset
  output logic o_recov_rst,                       // Recovered domain reset
  output logic o_ref_rst,                         // Reference domain reset
  output logic o_irq                              // Interrupt, level high
);
  import retimer_regs_pkg::*;

  // Address decode helper, used for every register
  function automatic logic hit(input addr_t a, input logic page,
                               input byte_t off);
    hit = (a[`PAGE_BIT] == page) && (a[7:0] == off);
  endfunction

  // Loss event: was acquired, now gone, feature enabled
  function automatic logic lost_event(input logic was, input logic now,
                                      input logic en);
    lost_event = was & ~now & en;
  endfunction

  // Attempt count as shown: saturates so 64 still fits six bits
  function automatic logic [5:0] shown_count(input logic [6:0] c);
    shown_count = (c[6]) ? `LOAD_SHOWN_MAX : c[5:0];
  endfunction

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_s1_r; // First release stage
  logic rst_n_r;  // Released reset used by all logic

  // Release through two flops; not gated by the clock enable, so a
  // frozen block still leaves reset cleanly
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic sig_s1_r, sig_s2_r;    // Signal detect
  logic lock_s1_r, lock_s2_r;  // Lock
  logic pol_s1_r, pol_s2_r;    // Polarity
  logic ref_s1_r, ref_s2_r;    // Reference present
  pat_code_t pat_s1_r;         // Pattern, first stage
  pat_code_t pat_s2_r;         // Pattern, second stage
  pat_code_t pat_s3_r;         // Pattern, comparison stage
  pat_code_t pat_r;            // Pattern, accepted value

  // Two flops per pin before any logic reads it
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sig_s1_r <= 1'b0;
      sig_s2_r <= 1'b0;
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
      pol_s1_r <= 1'b0;
      pol_s2_r <= 1'b0;
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      pat_s1_r <= 4'h0;
      pat_s2_r <= 4'h0;
      pat_s3_r <= 4'h0;
    end else if (i_clk_en) begin
      sig_s1_r <= i_sig_detect_pin;
      sig_s2_r <= sig_s1_r;
      lock_s1_r <= i_lock_pin;
      lock_s2_r <= lock_s1_r;
      pol_s1_r <= i_pol_inv_pin;
      pol_s2_r <= pol_s1_r;
      ref_s1_r <= i_ref_clk_present_pin;
      ref_s2_r <= ref_s1_r;
      pat_s1_r <= i_pattern_pin;
      pat_s2_r <= pat_s1_r;
      pat_s3_r <= pat_s2_r;
    end
  end

  // A four-bit code may be caught mid-change; only a value seen
  // twice in a row is taken, at the cost of one more cycle
  wire pat_stable = (pat_s2_r == pat_s3_r);

  // Accepted pattern code
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pat_r <= 4'h0;
    end else if (i_clk_en && pat_stable) begin
      pat_r <= pat_s3_r;
    end
  end

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire wr_reset_ctrl = i_wr && hit(i_addr, `PAGE_CHAN, `OFF_RESET_CTRL);
  wire wr_obs_sel = i_wr && hit(i_addr, `PAGE_CHAN, `OFF_OBS_SELECT);
  wire wr_event_en = i_wr && hit(i_addr, `PAGE_CHAN, `OFF_EVENT_EN);
  wire wr_irq_stat = i_wr && hit(i_addr, `PAGE_CHAN, `OFF_IRQ_STATUS);
  wire wr_irq_mask = i_wr && hit(i_addr, `PAGE_CHAN, `OFF_IRQ_MASK);
  wire wr_speed = i_wr && hit(i_addr, `PAGE_SHARED, `OFF_LOAD_SPEED);
  wire rd_event = i_rd && hit(i_addr, `PAGE_CHAN, `OFF_EVENT_STAT);

  // ---------------------------------------------------------------
  // Channel control registers
  // ---------------------------------------------------------------
  byte_t reset_ctrl_r; // Domain and register resets
  byte_t obs_sel_r;    // Observe select in upper nibble
  byte_t event_en_r;   // Event feature enables
  wire regs_rst = reset_ctrl_r[`BIT_REGS_RST];

  // Register reset wins over a write and clears itself with the rest
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reset_ctrl_r <= `RST_RESET_CTRL;
      obs_sel_r <= `RST_OBS_SELECT;
      event_en_r <= `RST_EVENT_EN;
    end else if (i_clk_en) begin
      if (regs_rst) begin
        reset_ctrl_r <= `RST_RESET_CTRL;
        obs_sel_r <= `RST_OBS_SELECT;
        event_en_r <= `RST_EVENT_EN;
      end else begin
        if (wr_reset_ctrl) begin
          reset_ctrl_r <= i_wr_data;
        end
        if (wr_obs_sel) begin
          obs_sel_r <= i_wr_data;
        end
        if (wr_event_en) begin
          event_en_r <= i_wr_data;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Domain reset outputs
  // ---------------------------------------------------------------
  wire core_rst = reset_ctrl_r[`BIT_CORE_RST];
  // Reference reset needs the reference clock to take effect
  wire ref_rst_nxt = reset_ctrl_r[`BIT_REF_RST] & ref_s2_r;

  // Registered so every output comes from a flop
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_core_rst <= 1'b0;
      o_recov_rst <= 1'b0;
      o_ref_rst <= 1'b0;
    end else if (i_clk_en) begin
      o_core_rst <= core_rst;
      o_recov_rst <= reset_ctrl_r[`BIT_RECOV_RST];
      o_ref_rst <= ref_rst_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Loss detection state machines (core domain)
  // ---------------------------------------------------------------
  logic locked_seen_r; // Lock acquired since last loss
  logic sig_seen_r;    // Signal acquired since last loss
  logic lock_lost_r;   // Lock-loss event flag
  logic sig_lost_r;    // Signal-loss event flag

  wire lock_en = event_en_r[`BIT_LOCK_EN];
  wire sig_en = event_en_r[`BIT_SIG_EN];
  wire lock_lost_set = lost_event(locked_seen_r, lock_s2_r, lock_en);
  wire sig_lost_set = lost_event(sig_seen_r, sig_s2_r, sig_en);

  // Acquisition history; held in reset by the core reset bit
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      locked_seen_r <= 1'b0;
      sig_seen_r <= 1'b0;
    end else if (i_clk_en) begin
      if (core_rst) begin
        locked_seen_r <= 1'b0;
        sig_seen_r <= 1'b0;
      end else begin
        locked_seen_r <= lock_s2_r;
        sig_seen_r <= sig_s2_r;
      end
    end
  end

  // Clear on read; an event in the read cycle sets and is kept
  wire lock_lost_nxt = lock_lost_set | (lock_lost_r & ~rd_event);
  wire sig_lost_nxt = sig_lost_set | (sig_lost_r & ~rd_event);

  // Event flags, enable gated in the set term
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lock_lost_r <= 1'b0;
      sig_lost_r <= 1'b0;
    end else if (i_clk_en) begin
      if (regs_rst) begin
        lock_lost_r <= 1'b0;
        sig_lost_r <= 1'b0;
      end else begin
        lock_lost_r <= lock_lost_nxt;
        sig_lost_r <= sig_lost_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [1:0] irq_stat_r; // Sticky, write one to clear
  logic [1:0] irq_mask_r; // One enables the bit onto o_irq
  wire [1:0] irq_set = {lock_lost_set, sig_lost_set};
  wire [1:0] irq_clr = wr_irq_stat ? i_wr_data[1:0] : 2'h0;
  // Set wins over a clear in the same cycle
  wire [1:0] irq_stat_nxt = irq_set | (irq_stat_r & ~irq_clr);

  // Sticky status and mask
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_stat_r <= `RST_IRQ;
      irq_mask_r <= `RST_IRQ;
    end else if (i_clk_en) begin
      if (regs_rst) begin
        irq_stat_r <= `RST_IRQ;
        irq_mask_r <= `RST_IRQ;
      end else begin
        irq_stat_r <= irq_stat_nxt;
        if (wr_irq_mask) begin
          irq_mask_r <= i_wr_data[1:0];
        end
      end
    end
  end

  // Interrupt level from the masked status
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Shared: configuration load tracking
  // ---------------------------------------------------------------
  byte_t speed_r;           // Speed select register
  load_state_t load_st_r;   // Load sequence state
  load_state_t load_st_nxt; // Next load state
  logic [6:0] attempts_r;   // Attempts, up to 64

  wire at_limit = (attempts_r == `LOAD_MAX_ATTEMPTS);
  wire [6:0] attempts_inc = attempts_r + 7'h01;

  // Load sequence: busy until success or the last attempt fails
  always_comb begin
    load_st_nxt = load_st_r;
    case (load_st_r)
      LOAD_BUSY: begin
        if (i_load_ok) begin
          load_st_nxt = LOAD_DONE;
        end else if (i_load_err && at_limit) begin
          load_st_nxt = LOAD_FAIL;
        end
      end
      LOAD_DONE: load_st_nxt = LOAD_DONE; // Held until reset
      LOAD_FAIL: load_st_nxt = LOAD_FAIL; // Held until reset
      default: load_st_nxt = LOAD_BUSY;   // Illegal code recovers
    endcase
  end

  // Status code from the one-hot state
  wire [1:0] load_code = (load_st_r == LOAD_DONE) ? `LOAD_CODE_DONE :
                         (load_st_r == LOAD_FAIL) ? `LOAD_CODE_FAIL :
                         `LOAD_CODE_BUSY;

  // State and attempt counter; counting stops once the load ends
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      load_st_r <= LOAD_BUSY;
      attempts_r <= 7'h00;
    end else if (i_clk_en) begin
      load_st_r <= load_st_nxt;
      if (i_load_attempt && load_st_r == LOAD_BUSY && !at_limit) begin
        attempts_r <= attempts_inc;
      end
    end
  end

  // Speed register, shared page, untouched by channel register reset
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      speed_r <= `RST_LOAD_SPEED;
    end else if (i_clk_en && wr_speed) begin
      speed_r <= i_wr_data;
    end
  end

  // ---------------------------------------------------------------
  // Load bit-rate tick
  // ---------------------------------------------------------------
  localparam logic [8:0] FAST_LAST = 9'(`FAST_DIV - 1);
  localparam logic [8:0] STD_LAST = 9'(`STD_DIV - 1);
  logic [8:0] tick_cnt_r; // Divider count
  wire fast = speed_r[`BIT_LOAD_FAST];
  wire [8:0] tick_last = fast ? FAST_LAST : STD_LAST;
  // A speed change mid-count may run past the new limit; >= ends it
  wire tick_wrap = (tick_cnt_r >= tick_last);
  wire [8:0] tick_inc = tick_cnt_r + 9'h001;

  // Divider runs only while the load is in progress
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_cnt_r <= 9'h000;
      o_load_tick <= 1'b0;
      o_load_fast <= 1'b0;
    end else if (i_clk_en) begin
      o_load_fast <= fast;
      if (load_st_r != LOAD_BUSY || tick_wrap) begin
        tick_cnt_r <= 9'h000;
      end else begin
        tick_cnt_r <= tick_inc;
      end
      o_load_tick <= (load_st_r == LOAD_BUSY) && tick_wrap;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  wire [3:0] obs_sel = obs_sel_r[`OBS_SEL_HI:`OBS_SEL_LO];
  wire [7:0] obs_byte = i_observe_src[{obs_sel, 3'h0} +: 8];
  // Raw detect and polarity pass straight through, not latched
  wire [7:0] event_word = {sig_s2_r, pol_s2_r, lock_lost_r, pat_r,
                           sig_lost_r};
  wire [7:0] load_word = {load_code, shown_count(attempts_r)};

  // Read mux; unmapped addresses read as zero
  wire [7:0] rd_mux =
    hit(i_addr, `PAGE_CHAN, `OFF_RESET_CTRL) ? reset_ctrl_r :
    hit(i_addr, `PAGE_CHAN, `OFF_EVENT_STAT) ? event_word :
    hit(i_addr, `PAGE_CHAN, `OFF_OBSERVE) ? obs_byte :
    hit(i_addr, `PAGE_CHAN, `OFF_OBS_SELECT) ? obs_sel_r :
    hit(i_addr, `PAGE_CHAN, `OFF_EVENT_EN) ? event_en_r :
    hit(i_addr, `PAGE_CHAN, `OFF_IRQ_STATUS) ? {6'h00, irq_stat_r} :
    hit(i_addr, `PAGE_CHAN, `OFF_IRQ_MASK) ? {6'h00, irq_mask_r} :
    hit(i_addr, `PAGE_SHARED, `OFF_LOAD_STATUS) ? load_word :
    hit(i_addr, `PAGE_SHARED, `OFF_LOAD_SPEED) ? speed_r :
    8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_rd_data <= 8'h00;
    end else if (i_clk_en) begin
      o_rd_data <= i_rd ? rd_mux : 8'h00;
    end
  end

endmodule

/* File: shared/retimer_regs_cfg.svh */
// Constants for the retimer channel control and status register bank.
// Assumes inclusion by bare name from the package and the design module.
`ifndef RETIMER_REGS_CFG_SVH
`define RETIMER_REGS_CFG_SVH

// Address page: bit 8 set selects the shared page
`define PAGE_BIT 8
`define PAGE_CHAN 1'b0
`define PAGE_SHARED 1'b1

// Shared page offsets
`define OFF_LOAD_STATUS 8'h11
`define OFF_LOAD_SPEED 8'h12
// Channel page offsets
`define OFF_RESET_CTRL 8'h00
`define OFF_EVENT_STAT 8'h01
`define OFF_OBSERVE 8'h02
`define OFF_OBS_SELECT 8'h0c
`define OFF_EVENT_EN 8'h31
`define OFF_IRQ_STATUS 8'h40
`define OFF_IRQ_MASK 8'h41

// Reset control field positions
`define BIT_CORE_RST 3
`define BIT_REGS_RST 2
`define BIT_RECOV_RST 1
`define BIT_REF_RST 0
// Speed select bit, observe select field, event enables
`define BIT_LOAD_FAST 7
`define OBS_SEL_HI 7
`define OBS_SEL_LO 4
`define BIT_LOCK_EN 1
`define BIT_SIG_EN 0
// Interrupt status and mask layout
`define IRQ_SIG_LOST 0
`define IRQ_LOCK_LOST 1

// Reset values
`define RST_RESET_CTRL 8'h00
`define RST_LOAD_SPEED 8'h91
`define RST_OBS_SELECT 8'h00
`define RST_EVENT_EN 8'h00
`define RST_IRQ 2'h0

// Load status codes and attempt limit
`define LOAD_CODE_BUSY 2'h0
`define LOAD_CODE_FAIL 2'h1
`define LOAD_CODE_DONE 2'h2
`define LOAD_MAX_ATTEMPTS 7'h40
`define LOAD_SHOWN_MAX 6'h3f

// Timing: memory load bit rate ticks
`define CLK_HZ 40000000
`define FAST_HZ 400000
`define STD_HZ 100000
`define FAST_DIV (`CLK_HZ / `FAST_HZ)
`define STD_DIV (`CLK_HZ / `STD_HZ)

`endif

/* File: shared/retimer_regs_pkg.sv */
// Types shared by the retimer register bank and its bench.
// Assumes the constants header is on the include path.
package retimer_regs_pkg;
  `include "retimer_regs_cfg.svh"

  typedef logic [7:0] byte_t;      // Register data
  typedef logic [8:0] addr_t;      // Page bit plus byte offset
  typedef logic [3:0] pat_code_t;  // Detected pattern code
  typedef logic [127:0] obs_bus_t; // Sixteen observable bytes

  // Configuration load sequence
  typedef enum logic [2:0] {
    LOAD_BUSY = 3'b001,
    LOAD_DONE = 3'b010,
    LOAD_FAIL = 3'b100
  } load_state_t;
endpackage

/* File: testbench/retimer_regs_asserts.sv */
// Port-level checker for the retimer channel register bank.
// Assumes it is bound to the bank top and sees only its ports.
module retimer_regs_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire retimer_regs_pkg::addr_t i_addr,
  input wire retimer_regs_pkg::byte_t i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire retimer_regs_pkg::byte_t o_rd_data,
  input wire logic i_sig_detect_pin,
  input wire logic i_pol_inv_pin,
  input wire logic i_ref_clk_present_pin,
  input wire logic o_load_tick,
  input wire logic o_core_rst,
  input wire logic o_recov_rst,
  input wire logic o_ref_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  import retimer_regs_pkg::*;
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  rd_idle_a: assert property (
    !$past(i_rd) |-> o_rd_data == 8'h00) else $error("read data not idle");
  core_rst_a: assert property (
    i_wr && i_addr == 9'h000 && i_wr_data[3:2] == 2'b10 |-> ##[1:2] o_core_rst)
    else $error("core reset not driven");
  recov_rst_a: assert property (
    i_wr && i_addr == 9'h000 && i_wr_data[2:1] == 2'b01 |-> ##[1:2] o_recov_rst)
    else $error("recovered reset not driven");
  // Four idle cycles outlast the two-flop sync of the presence pin
  ref_gate_a: assert property (
    (!i_ref_clk_present_pin)[*4] |-> !o_ref_rst) else $error("ref reset ungated");
  regs_clear_a: assert property (
    i_wr && i_addr == 9'h000 && i_wr_data[2] |-> ##3 !o_core_rst && !o_recov_rst)
    else $error("register reset left resets set");
  raw_sig_a: assert property (
    $stable(i_sig_detect_pin)[*6] ##0 (i_rd && i_addr == 9'h001)
    |=> o_rd_data[7] == $past(i_sig_detect_pin)) else $error("raw signal bit");
  pol_flag_a: assert property (
    $stable(i_pol_inv_pin)[*6] ##0 (i_rd && i_addr == 9'h001)
    |=> o_rd_data[6] == $past(i_pol_inv_pin)) else $error("polarity bit");
  load_code_a: assert property (
    i_rd && i_addr == 9'h111 |=> o_rd_data[7:6] != 2'b11)
    else $error("invalid load code");
  tick_pulse_a: assert property (
    o_load_tick |=> (!o_load_tick)[*8]) else $error("load tick too close");
endmodule

bind retimer_channel_control_status_regs retimer_regs_asserts
  retimer_regs_asserts_i (.*);

/* File: testbench/retimer_far_side_model.sv */
// Far side of the bank: channel status pins, observe sources, load engine.
// Assumes its tasks are called from the bench on the bank clock.
module retimer_far_side_model (
  input wire logic i_clk,
  output logic o_sig,
  output logic o_lock,
  output logic o_pol,
  output retimer_regs_pkg::pat_code_t o_pat,
  output logic o_ref,
  output retimer_regs_pkg::obs_bus_t o_obs,
  output logic o_att,
  output logic o_ok,
  output logic o_err
);
  timeunit 1ns;
  timeprecision 1ps;
  import retimer_regs_pkg::*;
  // Quiet line: no signal, no lock, no load activity
  initial begin
    {o_sig, o_lock, o_pol, o_ref, o_att, o_ok, o_err} = 7'h00;
    o_pat = 4'h0;
    o_obs = '0;
  end
  // Pins move just after an edge; the bank syncs them anyway
  task automatic drive(input logic s, l, p, input pat_code_t c, input logic r);
    @(posedge i_clk);
    o_sig <= s;
    o_lock <= l;
    o_pol <= p;
    o_pat <= c;
    o_ref <= r;
  endtask
  // Observe bytes come from other logic on the same clock
  task automatic set_obs(input obs_bus_t v);
    @(posedge i_clk);
    o_obs <= v;
  endtask
  // One attempt, answered a cycle later; counts saturate in the bank
  task automatic attempt(input logic good);
    @(posedge i_clk);
    o_att <= 1'b1;
    @(posedge i_clk);
    o_att <= 1'b0;
    o_ok <= good;
    o_err <= ~good;
    @(posedge i_clk);
    o_ok <= 1'b0;
    o_err <= 1'b0;
  endtask
endmodule

/* File: testbench/retimer_channel_control_status_regs_tb_top.sv */
// Self-checking bench for the retimer channel register bank.
// Assumes the far-side model and the bound checker are compiled first.
module retimer_channel_control_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import retimer_regs_pkg::*;
  logic clk = 1'b0; // Bank clock, 40 MHz
  logic rst_n = 1'b0; // Reset, low
  addr_t addr = 9'h000; // Bus address
  byte_t wdata = 8'h00; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  byte_t rdata; // Read data
  logic sig, lock, pol, ref_ok, att, ok, err; // Far-side pins
  pat_code_t pat; // Pattern code pin
  obs_bus_t obs; // Observe sources
  logic fast, tick, core, recov, refr, irq; // Bank outputs
  int num_errors = 0; // Mismatches
  int checks = 0; // Comparisons
  integer seed = 32'hdcdb; // Fixed seed for repeatable runs

  always #12.5 clk = ~clk;

  retimer_far_side_model retimer_far_side_model_i (.i_clk(clk), .o_sig(sig),
    .o_lock(lock), .o_pol(pol), .o_pat(pat), .o_ref(ref_ok), .o_obs(obs),
    .o_att(att), .o_ok(ok), .o_err(err));
  // Clock enable tied high: freezing is not exercised here
  retimer_channel_control_status_regs retimer_channel_control_status_regs_i (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_addr(addr),
    .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rdata),
    .i_sig_detect_pin(sig), .i_lock_pin(lock), .i_pol_inv_pin(pol),
    .i_pattern_pin(pat), .i_ref_clk_present_pin(ref_ok), .i_observe_src(obs),
    .i_load_attempt(att), .i_load_ok(ok), .i_load_err(err),
    .o_load_fast(fast), .o_load_tick(tick), .o_core_rst(core),
    .o_recov_rst(recov), .o_ref_rst(refr), .o_irq(irq));

  // Event word layout: raw, polarity, lock lost, pattern, signal lost
  function automatic byte_t ev(input logic s, p, l, input pat_code_t c,
                               input logic g);
    return {s, p, l, c, g};
  endfunction
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Compare and count
  task automatic check(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  // Settle n cycles, sampling clear of the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bus_wr(input addr_t a, input byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic bus_rd(input addr_t a, output byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input addr_t a, input byte_t e, input string n);
    byte_t v;
    bus_rd(a, v);
    check(n, {8'h00, v}, {8'h00, e});
  endtask
  // Cycles between two load ticks
  task automatic tick_gap(input int e);
    int n;
    n = 0;
    while (!tick && n < 1000) begin
      cyc(1);
      n++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (!tick && n < 1000);
    check("tick gap", n[15:0], e[15:0]);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // Hang guard, far beyond the planned run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    pat_code_t codes[8] = '{4'h0, 4'h8, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    addr_t rr[4] = '{9'h000, 9'h00c, 9'h031, 9'h041};
    obs_bus_t ov;
    byte_t v;
    logic p;
    do_reset();
    rd_chk(9'h112, 8'h91, "speed");
    rd_chk(9'h0ff, 8'h00, "unmapped");
    check("fast", 16'(fast), 16'h1);
    tick_gap(40_000_000 / 400_000);
    bus_wr(9'h112, 8'h11);
    // Speed bit reaches the output one edge after the write lands
    cyc(2);
    check("slow", 16'(fast), 16'h0);
    tick_gap(40_000_000 / 100_000);
    bus_wr(9'h112, 8'h91);
    // Domain resets, reference gate on and off
    retimer_far_side_model_i.drive(1'b1, 1'b1, 1'b0, 4'h0, 1'b1);
    bus_wr(9'h000, 8'h0b);
    cyc(4);
    check("resets", 16'({core, recov, refr}), 16'h7);
    retimer_far_side_model_i.drive(1'b1, 1'b1, 1'b0, 4'h0, 1'b0);
    cyc(5);
    check("ref gated", 16'(refr), 16'h0);
    bus_wr(9'h000, 8'h00);
    bus_wr(9'h031, 8'h03);
    bus_wr(9'h041, 8'h03);
    // Eight pattern codes, 0, 8 and a to f, with random polarity
    foreach (codes[i]) begin
      p = 1'($random(seed));
      retimer_far_side_model_i.drive(1'b1, 1'b1, p, codes[i], 1'b1);
      // Pattern needs sync plus a stable repeat before it reads back
      cyc(5);
      rd_chk(9'h001, ev(1'b1, p, 1'b0, codes[i], 1'b0), "ev");
    end
    // Lock lost twice: flag clears on read and sets again
    repeat (2) begin
      retimer_far_side_model_i.drive(1'b1, 1'b0, 1'b0, 4'h0, 1'b1);
      cyc(5);
      check("irq", 16'(irq), 16'h1);
      rd_chk(9'h001, ev(1'b1, 1'b0, 1'b1, 4'h0, 1'b0), "lost");
      rd_chk(9'h001, ev(1'b1, 1'b0, 1'b0, 4'h0, 1'b0), "cor");
      rd_chk(9'h040, 8'h02, "irq st");
      bus_wr(9'h040, 8'h02);
      cyc(2);
      check("irq clr", 16'(irq), 16'h0);
      retimer_far_side_model_i.drive(1'b1, 1'b1, 1'b0, 4'h0, 1'b1);
      cyc(6);
    end
    // Lock loss disabled, then signal loss
    bus_wr(9'h031, 8'h01);
    retimer_far_side_model_i.drive(1'b1, 1'b0, 1'b0, 4'h0, 1'b1);
    cyc(6);
    rd_chk(9'h001, ev(1'b1, 1'b0, 1'b0, 4'h0, 1'b0), "no lost");
    retimer_far_side_model_i.drive(1'b0, 1'b0, 1'b0, 4'h0, 1'b1);
    cyc(6);
    check("irq sig", 16'(irq), 16'h1);
    rd_chk(9'h001, ev(1'b0, 1'b0, 1'b0, 4'h0, 1'b1), "sig lost");
    rd_chk(9'h001, 8'h00, "sig cor");
    // Observe byte for every select value
    ov = {$random(seed), $random(seed), $random(seed), $random(seed)};
    retimer_far_side_model_i.set_obs(ov);
    for (int s = 0; s < 16; s++) begin
      bus_wr(9'h00c, {4'(s), 4'h0});
      rd_chk(9'h002, ov[8*s +: 8], "observe");
    end
    // Register reset restores defaults and drops the interrupt
    bus_wr(9'h000, 8'h0e);
    cyc(3);
    foreach (rr[i]) rd_chk(rr[i], 8'h00, "defaults");
    check("irq def", 16'(irq), 16'h0);
    // Load: count, saturation at failure, read-only, success
    rd_chk(9'h111, 8'h00, "busy");
    repeat (3) retimer_far_side_model_i.attempt(1'b0);
    rd_chk(9'h111, 8'h03, "attempts");
    repeat (61) retimer_far_side_model_i.attempt(1'b0);
    bus_wr(9'h111, 8'h00);
    rd_chk(9'h111, {2'b01, 6'h3f}, "failed");
    do_reset();
    retimer_far_side_model_i.attempt(1'b0);
    retimer_far_side_model_i.attempt(1'b1);
    rd_chk(9'h111, {2'b10, 6'h02}, "done");
    end_sim();
  end
endmodule
